// ===== src/ofd_pkg.sv
// constants for the oscillator failure detector and calibration loops
// assumes one 50 MHz system clock; the pins are sampled, not used as clocks
// Function
// R1: on failure while driving system clock, switch to internal 2 MHz and raise NMI
// R2: on failure of a non-system external source, disable it, still raise NMI
// R3: judge external source against monitor oscillator, fail below 32 kHz
// R4: external source at exactly 32 kHz never flags a failure
// R5: failure detector is off after reset, enabled only by protected sequence
// R6: software writes 0xD8 to guard, then four cycles to set enable
// R7: once enabled, detector stays enabled until next system reset
// R8: failure interrupt cannot be masked by any setting
// R9: two independent calibration loops, slow 2 MHz and fast 32 MHz
// R10: an enabled loop keeps trimming its oscillator against the selected reference
// R11: sleep freezes loop state; wake resumes from the frozen state
// R12: a disabled loop keeps its last calibration value
// R13: reference select zero picks internal 32 kHz RC, one picks crystal
// R14: selecting a reference that is not yet stable has no effect
// R15: each loop holds a three-byte count reference loaded at reset
// R16: each loop has a two-byte word with enable and calibration value
// R17: software selects reference first, then enables; calibration starts at once
// R18: internal 32 kHz RC has no loop, only a software trim register
// R19: a detected failure releases the clock configuration lock
// R20: failure interrupt request held until acknowledged
package ofd_pkg;
    localparam logic [7:0] ADDR_GUARD = 8'h00;
    localparam logic [7:0] ADDR_FAIL = 8'h04;
    localparam logic [7:0] ADDR_CLKCTRL = 8'h08;
    localparam logic [7:0] ADDR_REFCTRL = 8'h0C;
    localparam logic [7:0] ADDR_LOOP0_CTRL = 8'h10;
    localparam logic [7:0] ADDR_LOOP1_CTRL = 8'h14;
    localparam logic [7:0] ADDR_LOOP0_CAL = 8'h18;
    localparam logic [7:0] ADDR_LOOP1_CAL = 8'h1C;
    localparam logic [7:0] ADDR_LOOP0_CNT = 8'h20;
    localparam logic [7:0] ADDR_LOOP1_CNT = 8'h24;
    localparam logic [7:0] ADDR_SLOW_TRIM = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2C;
    localparam logic [7:0] GUARD_KEY = 8'hD8;
    localparam logic [2:0] GUARD_CYCLES = 3'h4;
    localparam logic [1:0] FAIL_MON_EDGES = 2'h2;
    localparam int CAL_EN_BIT = 15;
    localparam logic [14:0] CAL_RST_SLOW = 15'h0040;
    localparam logic [14:0] CAL_RST_FAST = 15'h0040;
    localparam logic [23:0] CNT_RST_SLOW = 24'h00003D;
    localparam logic [23:0] CNT_RST_FAST = 24'h0003D0;
    localparam logic [7:0] SLOW_TRIM_RST = 8'h80;
    localparam int SY_EXT = 0;
    localparam int SY_MON = 1;
    localparam int SY_RC32K = 2;
    localparam int SY_XTAL = 3;
    localparam int SY_TICK0 = 4;
    localparam int SY_EXT_RDY = 6;
    localparam int SY_RC_RDY = 7;
    localparam int SY_XTAL_RDY = 8;
    localparam int SY_N = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== src/ofd_top.sv
// oscillator failure detector, two calibration loops and AXI4-Lite registers
// assumes all oscillator pins and ready levels arrive asynchronously to aclk
`timescale 1ns/1ps
module ofd_top #(
    parameter int CAL_W = 15,
    parameter int CNT_W = 24
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_osc_clk,
    input wire logic monitor_oscillator,
    input wire logic rc32k_clk,
    input wire logic xtal32k_clk,
    input wire logic [1:0] loop_osc_tick,
    input wire logic ext_osc_ready,
    input wire logic rc32k_ready,
    input wire logic xtal32k_ready,
    input wire logic sleep_active,
    input wire logic nmi_ack,
    output logic nmi_req,
    output logic irq_hold,
    output logic fail_detect_enable,
    output logic ext_osc_enable,
    output logic sys_clk_sel_ext,
    output logic clk_config_lock,
    output logic [7:0] slow_rc_trim,
    output logic [CAL_W-1:0] slow_loop_cal,
    output logic [CAL_W-1:0] fast_loop_cal
);
    typedef struct packed {
        logic [ofd_pkg::SY_N-1:0] s1;
        logic [ofd_pkg::SY_N-1:0] s2;
        logic [ofd_pkg::SY_N-1:0] s3;
        logic [ofd_pkg::SY_N-1:0] flt;
        logic [2:0] guard_cnt;
        logic fd_en;
        logic fail_flag;
        logic nmi;
        logic ext_en;
        logic sys_ext;
        logic lock;
        logic [1:0] ref_sel;
        logic [1:0] loop_en;
        logic [1:0][CAL_W-1:0] cal;
        logic [1:0][CNT_W-1:0] cnt_ref;
        logic [1:0][CNT_W-1:0] osc_cnt;
        logic [7:0] slow_trim;
        logic [1:0] mon_cnt;
        logic aw_held;
        logic w_held;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } ofd_state_t;

    ofd_state_t st_reg;
    ofd_state_t st_next;
    logic [ofd_pkg::SY_N-1:0] rise;
    logic [1:0] ref_rise;
    logic fail_event;
    logic guard_open;
    logic wr_fire;
    logic rd_fire;

    // merge a write into a 32-bit image by byte enables
    function automatic logic [31:0] ofd_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    assign guard_open = (st_reg.guard_cnt != 3'h0);
    assign wr_fire = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.w_held && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;

    always_comb begin
        logic [31:0] img;
        logic [31:0] rd;
        logic ok;
        ofd_state_t keep;
        img = '0;
        keep = '0;
        rd = '0;
        ok = 1'b1;
        st_next = st_reg;
        // three-stage sampling, change counts when stages two and three agree
        st_next.s1 = {xtal32k_ready, rc32k_ready, ext_osc_ready, loop_osc_tick,
            xtal32k_clk, rc32k_clk, monitor_oscillator, ext_osc_clk};
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int k = 0; k < ofd_pkg::SY_N; k++) begin
            if (st_reg.s2[k] == st_reg.s3[k]) begin
                st_next.flt[k] = st_reg.s3[k];
            end
        end
        rise = st_next.flt & ~st_reg.flt;
        if (st_reg.guard_cnt != 3'h0) begin
            st_next.guard_cnt = st_reg.guard_cnt - 3'h1;
        end

        // failure detection: too many monitor edges without an external edge
        fail_event = 1'b0;
        if (st_reg.fd_en && st_reg.ext_en) begin
            if (rise[ofd_pkg::SY_EXT]) begin
                st_next.mon_cnt = 2'h0;
            end else if (rise[ofd_pkg::SY_MON]) begin
                if (st_reg.mon_cnt == ofd_pkg::FAIL_MON_EDGES - 2'h1) begin
                    fail_event = 1'b1; // see R3 see R4
                    st_next.mon_cnt = 2'h0;
                end else begin
                    st_next.mon_cnt = st_reg.mon_cnt + 2'h1;
                end
            end
        end else begin
            st_next.mon_cnt = 2'h0;
        end

        // calibration loops, one per oscillator
        for (int i = 0; i < 2; i++) begin
            ref_rise[i] = st_reg.ref_sel[i] ? rise[ofd_pkg::SY_XTAL] : rise[ofd_pkg::SY_RC32K]; // see R13
            if (st_reg.loop_en[i] && !sleep_active) begin // see R9 see R11 see R12
                if (ref_rise[i]) begin // see R10
                    st_next.osc_cnt[i] = '0;
                    if (st_reg.osc_cnt[i] < st_reg.cnt_ref[i] && st_reg.cal[i] != '1) begin
                        st_next.cal[i] = st_reg.cal[i] + 1'b1;
                    end else if (st_reg.osc_cnt[i] > st_reg.cnt_ref[i] && st_reg.cal[i] != '0) begin
                        st_next.cal[i] = st_reg.cal[i] - 1'b1;
                    end
                end else if (rise[ofd_pkg::SY_TICK0 + i]) begin
                    st_next.osc_cnt[i] = st_reg.osc_cnt[i] + 1'b1;
                end
            end
        end

        // bus write side
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_held = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_held = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (wr_fire) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            img = ofd_merge('0, st_reg.wdata, st_reg.wstrb);
            unique case ({st_reg.awaddr[7:2], 2'b00})
                ofd_pkg::ADDR_GUARD: begin
                    if (st_reg.wstrb[0] && img[7:0] == ofd_pkg::GUARD_KEY) begin
                        st_next.guard_cnt = ofd_pkg::GUARD_CYCLES; // see R6
                    end
                end
                ofd_pkg::ADDR_FAIL: begin
                    if (guard_open && st_reg.wstrb[0] && img[0]) begin
                        st_next.fd_en = 1'b1; // see R5 see R6 see R7
                        st_next.guard_cnt = 3'h0;
                    end
                end
                ofd_pkg::ADDR_CLKCTRL: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.ext_en = img[0];
                        if (guard_open && !st_reg.lock) begin
                            st_next.sys_ext = img[1] && st_reg.flt[ofd_pkg::SY_EXT_RDY];
                            st_next.lock = img[2];
                            st_next.guard_cnt = 3'h0;
                        end
                    end
                end
                ofd_pkg::ADDR_REFCTRL: begin
                    for (int i = 0; i < 2; i++) begin
                        if (st_reg.wstrb[0]) begin
                            if (img[i] ? st_reg.flt[ofd_pkg::SY_XTAL_RDY] : st_reg.flt[ofd_pkg::SY_RC_RDY]) begin
                                st_next.ref_sel[i] = img[i]; // see R14
                            end
                        end
                    end
                end
                ofd_pkg::ADDR_LOOP0_CTRL, ofd_pkg::ADDR_LOOP1_CTRL: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.loop_en[st_reg.awaddr[2]] = img[0]; // see R17
                    end
                end
                ofd_pkg::ADDR_LOOP0_CAL, ofd_pkg::ADDR_LOOP1_CAL: begin
                    img = ofd_merge({16'h0000, st_reg.loop_en[st_reg.awaddr[2]], st_reg.cal[st_reg.awaddr[2]]},
                        st_reg.wdata, st_reg.wstrb);
                    st_next.cal[st_reg.awaddr[2]] = img[CAL_W-1:0]; // see R16
                    st_next.loop_en[st_reg.awaddr[2]] = img[ofd_pkg::CAL_EN_BIT];
                end
                ofd_pkg::ADDR_LOOP0_CNT, ofd_pkg::ADDR_LOOP1_CNT: begin
                    img = ofd_merge({8'h00, st_reg.cnt_ref[st_reg.awaddr[2]]}, st_reg.wdata, st_reg.wstrb);
                    st_next.cnt_ref[st_reg.awaddr[2]] = img[CNT_W-1:0]; // see R15
                end
                ofd_pkg::ADDR_SLOW_TRIM: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.slow_trim = img[7:0]; // see R18
                    end
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
            st_next.bresp = ok ? ofd_pkg::RESP_OKAY : ofd_pkg::RESP_SLVERR;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        // bus read side
        if (rd_fire) begin
            ok = 1'b1;
            unique case ({s_axi_araddr[7:2], 2'b00})
                ofd_pkg::ADDR_GUARD: rd = {31'h0, guard_open};
                ofd_pkg::ADDR_FAIL: rd = {30'h0, st_reg.fail_flag, st_reg.fd_en};
                ofd_pkg::ADDR_CLKCTRL: rd = {29'h0, st_reg.lock, st_reg.sys_ext, st_reg.ext_en};
                ofd_pkg::ADDR_REFCTRL: rd = {30'h0, st_reg.ref_sel};
                ofd_pkg::ADDR_LOOP0_CTRL, ofd_pkg::ADDR_LOOP1_CTRL: rd = {31'h0, st_reg.loop_en[s_axi_araddr[2]]};
                ofd_pkg::ADDR_LOOP0_CAL, ofd_pkg::ADDR_LOOP1_CAL:
                    rd = {16'h0000, st_reg.loop_en[s_axi_araddr[2]], st_reg.cal[s_axi_araddr[2]]};
                ofd_pkg::ADDR_LOOP0_CNT, ofd_pkg::ADDR_LOOP1_CNT: rd = {8'h00, st_reg.cnt_ref[s_axi_araddr[2]]};
                ofd_pkg::ADDR_SLOW_TRIM: rd = {24'h0, st_reg.slow_trim};
                ofd_pkg::ADDR_STATUS: rd = {28'h0, st_reg.flt[ofd_pkg::SY_XTAL_RDY], st_reg.flt[ofd_pkg::SY_RC_RDY],
                    st_reg.flt[ofd_pkg::SY_EXT_RDY], sleep_active};
                default: ok = 1'b0;
            endcase
            st_next.rvalid = 1'b1;
            st_next.rdata = rd;
            st_next.rresp = ok ? ofd_pkg::RESP_OKAY : ofd_pkg::RESP_SLVERR;
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // failure reaction wins over any software write in the same cycle
        if (nmi_ack) begin
            st_next.nmi = 1'b0;
        end
        if (fail_event) begin
            st_next.fail_flag = 1'b1;
            st_next.nmi = 1'b1; // see R8 see R20
            st_next.ext_en = 1'b0; // see R2
            st_next.sys_ext = 1'b0; // see R1
            st_next.lock = 1'b0; // see R19
        end

        if (!aresetn) begin
            keep = st_next;
            st_next = '0;
            st_next.s1 = keep.s1;
            st_next.s2 = keep.s2;
            st_next.s3 = keep.s3;
            st_next.flt = keep.flt;
            st_next.cal[0] = CAL_W'(ofd_pkg::CAL_RST_SLOW);
            st_next.cal[1] = CAL_W'(ofd_pkg::CAL_RST_FAST);
            st_next.cnt_ref[0] = CNT_W'(ofd_pkg::CNT_RST_SLOW);
            st_next.cnt_ref[1] = CNT_W'(ofd_pkg::CNT_RST_FAST);
            st_next.slow_trim = ofd_pkg::SLOW_TRIM_RST;
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = st_reg.rdata;
    assign nmi_req = st_reg.nmi;
    assign irq_hold = guard_open;
    assign fail_detect_enable = st_reg.fd_en;
    assign ext_osc_enable = st_reg.ext_en;
    assign sys_clk_sel_ext = st_reg.sys_ext;
    assign clk_config_lock = st_reg.lock;
    assign slow_rc_trim = st_reg.slow_trim;
    assign slow_loop_cal = st_reg.cal[0];
    assign fast_loop_cal = st_reg.cal[1];

    default clocking ofd_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_fd_enable_guarded: assert property ($rose(st_reg.fd_en) |-> $past(guard_open)) // see R5 see R6
        else $error("detector enabled outside guard window");
    a_fd_enable_sticky: assert property (st_reg.fd_en |=> st_reg.fd_en) // see R7
        else $error("detector enable dropped");
    a_fail_sysclk_switch: assert property (fail_event && st_reg.sys_ext |=> !st_reg.sys_ext && st_reg.nmi) // see R1
        else $error("system clock not moved to internal oscillator");
    a_fail_ext_off: assert property (fail_event |=> !st_reg.ext_en && st_reg.nmi && st_reg.fail_flag) // see R2
        else $error("failed source not disabled");
    a_fail_unlock: assert property (fail_event |=> !st_reg.lock) // see R19
        else $error("lock kept after failure");
    a_nmi_held: assert property (st_reg.nmi && !nmi_ack |=> st_reg.nmi) // see R8 see R20
        else $error("nmi dropped without acknowledge");
    a_fail_needs_enable: assert property (fail_event |-> st_reg.fd_en && rise[ofd_pkg::SY_MON]) // see R3
        else $error("failure without monitor edge");
    a_loop_frozen: assert property ((sleep_active || !st_reg.loop_en[0]) && !wr_fire |=> $stable(st_reg.cal[0])) // see R11 see R12
        else $error("slow loop moved while frozen");
    a_ref_stable: assert property ($rose(st_reg.ref_sel[0]) |-> $past(st_reg.flt[ofd_pkg::SY_XTAL_RDY])) // see R14
        else $error("unstable reference selected");

    a_fast_loop_frozen: assert property ( // see R11 see R12
        (sleep_active || !st_reg.loop_en[1]) && !wr_fire |=> $stable(st_reg.cal[1]))
        else $error("fast loop moved while frozen");

    a_fast_ref_stable: assert property ( // see R14
        $rose(st_reg.ref_sel[1]) |-> $past(st_reg.flt[ofd_pkg::SY_XTAL_RDY]))
        else $error("unstable fast reference selected");

    a_guard_countdown: assert property ( // see R6
        st_reg.guard_cnt != 3'h0 && !wr_fire |=> st_reg.guard_cnt == $past(st_reg.guard_cnt) - 3'h1)
        else $error("guard window not counting down");

    a_trim_sw_only: assert property ( // see R18
        !wr_fire |=> $stable(st_reg.slow_trim))
        else $error("slow trim moved without write");

    a_cnt_ref_kept: assert property ( // see R15
        !wr_fire |=> $stable(st_reg.cnt_ref))
        else $error("count reference moved without write");

    a_lock_kept: assert property ( // see R19
        st_reg.lock && !fail_event |=> st_reg.lock)
        else $error("lock dropped without failure");

    a_fd_reset_off: assert property ( // see R5
        $past(!aresetn) |-> !st_reg.fd_en)
        else $error("detector on after reset");

    a_ext_edge_no_fail: assert property ( // see R4
        rise[ofd_pkg::SY_EXT] |-> !fail_event)
        else $error("failure despite external edge");

    c_fail_sysclk: cover property (fail_event && st_reg.sys_ext);
    c_fail_aux: cover property (fail_event && !st_reg.sys_ext);
    c_cal_step: cover property (st_reg.loop_en[1] ##1 !$stable(st_reg.cal[1]));
    c_nmi_ack: cover property (st_reg.nmi ##1 nmi_ack ##1 !st_reg.nmi);
    c_ref_xtal: cover property ($rose(st_reg.ref_sel[0]));
endmodule

// ===== test/ofd_osc_model.sv
// partner model: external oscillator, monitor oscillator, loop references and ticks
// assumes the bench drives the run controls; all waves are async to aclk
`timescale 1ns/1ps
module ofd_osc_model (
    input wire logic ext_run,
    input wire logic xtal_run,
    input wire logic [1:0] tick_run,
    output logic ext_osc_clk,
    output logic monitor_oscillator,
    output logic rc32k_clk,
    output logic xtal32k_clk,
    output logic [1:0] loop_osc_tick,
    output logic ext_osc_ready,
    output logic rc32k_ready,
    output logic xtal32k_ready
);
    assign ext_osc_ready = ext_run;
    assign rc32k_ready = 1'b1;
    assign xtal32k_ready = xtal_run;
    initial begin
        monitor_oscillator = 1'b0;
        forever #1000 monitor_oscillator = ~monitor_oscillator;
    end
    // same rate as the monitor, half a phase later; a failed source stops low
    initial begin
        ext_osc_clk = 1'b0;
        #500;
        forever #1000 ext_osc_clk = ext_run ? ~ext_osc_clk : 1'b0;
    end
    initial begin
        rc32k_clk = 1'b0;
        forever #10000 rc32k_clk = ~rc32k_clk;
    end
    initial begin
        xtal32k_clk = 1'b0;
        #3000;
        forever #10000 xtal32k_clk = xtal_run ? ~xtal32k_clk : 1'b0;
    end
    // stopped ticks stand still
    initial begin
        loop_osc_tick = 2'h0;
        forever #80 loop_osc_tick = loop_osc_tick ^ tick_run;
    end
endmodule

// ===== test/ofd_top_bench.sv
// self-checking bench for the failure detector and calibration loops
// assumes ofd_top with default widths and the oscillator partner model
`timescale 1ns/1ps
module ofd_top_bench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, slow_rc_trim;
    logic [31:0] wdata, rdata, rdv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp, tick, tick_run;
    logic ext_clk, mon, rc_clk, xt_clk, ext_rdy, rc_rdy, xt_rdy, ext_run, xtal_run, sleep_active, nmi_ack;
    logic nmi_req, irq_hold, fail_detect_enable, ext_osc_enable, sys_clk_sel_ext, clk_config_lock;
    logic [14:0] slow_loop_cal, fast_loop_cal, s0, f0;
    int error_cnt, check_count;
    ofd_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_osc_clk(ext_clk),
        .monitor_oscillator(mon), .rc32k_clk(rc_clk), .xtal32k_clk(xt_clk), .loop_osc_tick(tick),
        .ext_osc_ready(ext_rdy), .rc32k_ready(rc_rdy), .xtal32k_ready(xt_rdy), .sleep_active(sleep_active),
        .nmi_ack(nmi_ack), .nmi_req(nmi_req), .irq_hold(irq_hold), .fail_detect_enable(fail_detect_enable),
        .ext_osc_enable(ext_osc_enable), .sys_clk_sel_ext(sys_clk_sel_ext), .clk_config_lock(clk_config_lock),
        .slow_rc_trim(slow_rc_trim), .slow_loop_cal(slow_loop_cal), .fast_loop_cal(fast_loop_cal));
    ofd_osc_model osc (.ext_run(ext_run), .xtal_run(xtal_run), .tick_run(tick_run), .ext_osc_clk(ext_clk),
        .monitor_oscillator(mon), .rc32k_clk(rc_clk), .xtal32k_clk(xt_clk), .loop_osc_tick(tick),
        .ext_osc_ready(ext_rdy), .rc32k_ready(rc_rdy), .xtal32k_ready(xt_rdy));
    always #10 aclk = ~aclk;
    task complete_run;
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task to_fail;
        error_cnt++;
        complete_run();
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            if (++n > 40) to_fail();
        end
        do @(posedge aclk); while (bvalid !== 1'b1 && ++n < 80);
        if (bvalid !== 1'b1) to_fail();
        rsp = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1 && ++n < 40);
        if (arready !== 1'b1) to_fail();
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1 && ++n < 80);
        if (rvalid !== 1'b1) to_fail();
        rdv = rdata;
        rsp = rresp;
    endtask
    task automatic wait_nmi;
        int n;
        n = 0;
        do @(posedge aclk); while (nmi_req !== 1'b1 && ++n < 400);
        if (nmi_req !== 1'b1) to_fail();
        cyc(1);
    endtask
    task ack_nmi;
        nmi_ack <= 1'b1;
        cyc(2);
        nmi_ack <= 1'b0;
        cyc(2);
        chk(nmi_req, 1'b0);
    endtask
    task t_reset;
        chk(fail_detect_enable, 1'b0);
        rd(ofd_pkg::ADDR_LOOP0_CNT);
        chk(rdv, {8'h00, ofd_pkg::CNT_RST_SLOW});
        rd(ofd_pkg::ADDR_LOOP1_CNT);
        chk(rdv, {8'h00, ofd_pkg::CNT_RST_FAST});
        rd(ofd_pkg::ADDR_LOOP0_CAL);
        chk(rdv, {17'h00000, ofd_pkg::CAL_RST_SLOW});
        rd(ofd_pkg::ADDR_LOOP1_CAL);
        chk(rdv, {17'h00000, ofd_pkg::CAL_RST_FAST});
        rd(8'h30);
        chk(rsp, ofd_pkg::RESP_SLVERR);
        wr(8'h30, 32'h00000001);
        chk(rsp, ofd_pkg::RESP_SLVERR);
        chk(slow_rc_trim, ofd_pkg::SLOW_TRIM_RST);
        wr(ofd_pkg::ADDR_SLOW_TRIM, 32'h0000005A);
        chk(slow_rc_trim, 8'h5A);
        chk(rsp, ofd_pkg::RESP_OKAY);
    endtask
    task t_guard;
        wr(ofd_pkg::ADDR_FAIL, 32'h00000001);
        chk(fail_detect_enable, 1'b0);
        wr(ofd_pkg::ADDR_GUARD, {24'h000000, ofd_pkg::GUARD_KEY});
        chk(irq_hold, 1'b1);
        wr(ofd_pkg::ADDR_FAIL, 32'h00000001);
        chk(fail_detect_enable, 1'b1);
        wr(ofd_pkg::ADDR_GUARD, {24'h000000, ofd_pkg::GUARD_KEY});
        wr(ofd_pkg::ADDR_FAIL, 32'h00000000);
        chk(fail_detect_enable, 1'b1);
        cyc(6);
        chk(irq_hold, 1'b0);
    endtask
    task t_fail_aux;
        ext_run <= 1'b1;
        wr(ofd_pkg::ADDR_CLKCTRL, 32'h00000001);
        cyc(600);
        chk(nmi_req, 1'b0);
        chk(ext_osc_enable, 1'b1);
        ext_run <= 1'b0;
        wait_nmi();
        chk(ext_osc_enable, 1'b0);
        chk(sys_clk_sel_ext, 1'b0);
        cyc(50);
        chk(nmi_req, 1'b1);
        rd(ofd_pkg::ADDR_FAIL);
        chk(rdv, 32'h00000003);
        ack_nmi();
    endtask
    task t_fail_sys;
        ext_run <= 1'b1;
        cyc(300);
        wr(ofd_pkg::ADDR_CLKCTRL, 32'h00000001);
        wr(ofd_pkg::ADDR_GUARD, {24'h000000, ofd_pkg::GUARD_KEY});
        wr(ofd_pkg::ADDR_CLKCTRL, 32'h00000007);
        chk(sys_clk_sel_ext, 1'b1);
        chk(clk_config_lock, 1'b1);
        wr(ofd_pkg::ADDR_GUARD, {24'h000000, ofd_pkg::GUARD_KEY});
        wr(ofd_pkg::ADDR_CLKCTRL, 32'h00000001);
        chk(sys_clk_sel_ext, 1'b1);
        ext_run <= 1'b0;
        wait_nmi();
        chk(nmi_req, 1'b1);
        chk(sys_clk_sel_ext, 1'b0);
        chk(ext_osc_enable, 1'b0);
        chk(clk_config_lock, 1'b0);
        ack_nmi();
    endtask
    task t_loops;
        wr(ofd_pkg::ADDR_REFCTRL, 32'h00000003);
        rd(ofd_pkg::ADDR_REFCTRL);
        chk(rdv, 32'h00000000);
        xtal_run <= 1'b1;
        cyc(10);
        wr(ofd_pkg::ADDR_REFCTRL, 32'h00000003);
        rd(ofd_pkg::ADDR_REFCTRL);
        chk(rdv, 32'h00000003);
        rd(ofd_pkg::ADDR_STATUS);
        chk(rdv, 32'h0000000C);
        wr(ofd_pkg::ADDR_REFCTRL, 32'h00000000);
        wr(ofd_pkg::ADDR_LOOP1_CNT, 32'h00000010);
        tick_run <= 2'h1;
        wr(ofd_pkg::ADDR_LOOP0_CTRL, 32'h00000001);
        wr(ofd_pkg::ADDR_LOOP1_CTRL, 32'h00000001);
        cyc(3000);
        chk(slow_loop_cal < 15'h0040, 1'b1);
        chk(fast_loop_cal > 15'h0040, 1'b1);
        rd(ofd_pkg::ADDR_LOOP0_CAL);
        chk(rdv[ofd_pkg::CAL_EN_BIT], 1'b1);
        sleep_active <= 1'b1;
        cyc(2);
        s0 = slow_loop_cal;
        f0 = fast_loop_cal;
        cyc(3000);
        chk(slow_loop_cal, s0);
        chk(fast_loop_cal, f0);
        sleep_active <= 1'b0;
        cyc(3000);
        chk(slow_loop_cal < s0, 1'b1);
        chk(fast_loop_cal > f0, 1'b1);
        wr(ofd_pkg::ADDR_LOOP0_CTRL, 32'h00000000);
        wr(ofd_pkg::ADDR_LOOP1_CTRL, 32'h00000000);
        s0 = slow_loop_cal;
        f0 = fast_loop_cal;
        cyc(3000);
        chk(slow_loop_cal, s0);
        chk(fast_loop_cal, f0);
        wr(ofd_pkg::ADDR_LOOP0_CAL, 32'h00000055);
        chk(slow_loop_cal, 15'h0055);
        chk(slow_rc_trim, 8'h5A);
    endtask
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, arvalid, ext_run, xtal_run, sleep_active, nmi_ack} = 7'h00;
        {bready, rready} = 2'h3;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        tick_run = 2'h0;
        error_cnt = 0;
        check_count = 0;
        cyc(5);
        aresetn <= 1'b1;
        cyc(1);
        t_reset();
        t_guard();
        t_fail_aux();
        t_fail_sys();
        t_loops();
        complete_run();
    end
endmodule
